// ===== hw/rap_pkg.sv
// Package for the radio auxiliary pin block: register map, fields, command codes, carriers.
package rap_pkg;

  localparam logic [5:0] TRX_CTRL_ONE_ADDR = 6'h04;
  localparam logic [5:0] ANT_DIV_CTRL_ADDR = 6'h0D;
  localparam logic [5:0] EXT_MODE_CTRL_ONE_ADDR = 6'h17;

  localparam logic [7:0] TRX_CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] ANT_DIV_CTRL_RESET = 8'h00;
  localparam logic [7:0] EXT_MODE_CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] EXT_MODE_CTRL_ONE_MASK = 8'hF7;
  localparam logic [7:0] ANT_DIV_CTRL_MASK = 8'h07;

  localparam int TS_PIN_EN_BIT = 6;
  localparam int BUF_IND_EN_BIT = 4;
  localparam int RETRY_STAMP_EN_BIT = 7;
  localparam int SW_DRIVE_EN_BIT = 2;
  localparam int ANT_SEL_LSB = 0;

  localparam logic [1:0] ANT_SEL_ZERO = 2'h1;
  localparam logic [1:0] ANT_SEL_ONE = 2'h2;

  localparam logic [1:0] CMD_REG_READ = 2'h2;
  localparam logic [1:0] CMD_REG_WRITE = 2'h3;
  localparam logic [2:0] CMD_FRAME_READ = 3'h1;

  localparam int CLK_PERIOD_NS = 10;
  localparam int IND_VALID_NS = 750;
  localparam int IND_VALID_CYCLES = IND_VALID_NS / CLK_PERIOD_NS;

  localparam logic [2:0] PIN_SYNC_RESET = 3'h4;

  typedef struct packed {
    logic rx_phr_valid;
    logic tx_frame_start;
    logic frame_end;
    logic rx_error;
  } rap_core_evt_type;

  typedef struct packed {
    logic switch_pos;
    logic switch_neg;
    logic irq_pin;
    logic miso;
    logic miso_oe_n;
  } rap_pins_type;

  typedef enum logic [2:0] {
    SPI_IDLE,
    SPI_REG_WRITE,
    SPI_REG_READ,
    SPI_FRAME_READ,
    SPI_OTHER
  } rap_spi_state_type;

endpackage

// ===== hw/rap_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module rap_pin_sync
  import rap_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        stage1[i] <= RESET_VAL[i];
        stage2[i] <= RESET_VAL[i];
        stage3[i] <= RESET_VAL[i];
        pin_out[i] <= RESET_VAL[i];
      end
      else
      begin
        stage1[i] <= pin_in[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
        if (stage2[i] == stage3[i])
        begin
          pin_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// ===== hw/rap_spi_shift.sv
// Serial byte shifter: samples on serial clock rise, shifts out on fall, MSB first.
`timescale 1ns/1ps
module rap_spi_shift
  import rap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic [7:0] tx_byte,
  output logic byte_done,
  output logic [7:0] rx_byte,
  output logic miso
);

  logic sclk_prev;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic load_pending;
  logic sclk_rise;
  logic sclk_fall;

  assign sclk_rise = sclk & ~sclk_prev & ~sel_n;
  assign sclk_fall = ~sclk & sclk_prev & ~sel_n;
  assign miso = shift_out[7];

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_prev <= 1'b0;
    end
    else
    begin
      sclk_prev <= sclk;
    end
  end

  // The byte answer is loaded two cycles after byte_done rises, long before the next fall.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      rx_byte <= 8'h00;
      byte_done <= 1'b0;
      load_pending <= 1'b0;
    end
    else
    begin
      byte_done <= 1'b0;
      load_pending <= byte_done;
      if (sel_n)
      begin
        bit_cnt <= 3'h0;
        shift_out <= 8'h00;
        load_pending <= 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          shift_in <= {shift_in[6:0], mosi};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7)
          begin
            rx_byte <= {shift_in[6:0], mosi};
            byte_done <= 1'b1;
          end
        end
        if (load_pending)
        begin
          shift_out <= tx_byte;
        end
        else if (sclk_fall && bit_cnt != 3'h0)
        begin
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// ===== hw/rap_aux_pins.sv
// Auxiliary pin logic: antenna switch control, frame time stamping, buffer-empty indicator.
`timescale 1ns/1ps
module rap_aux_pins
  import rap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic spi_sel_n,
  input wire rap_core_evt_type core_evt,
  input wire logic auto_retry_tx_mode,
  input wire logic buffer_data_ready,
  input wire logic irq_pending,
  output rap_pins_type pins
);

  logic sclk_s;
  logic mosi_s;
  logic sel_n_s;
  logic byte_done;
  logic [7:0] rx_byte;
  logic miso_raw;
  logic [7:0] transceiver_control_one;
  logic [7:0] extended_mode_control_one;
  logic [7:0] antenna_diversity_control;
  logic [7:0] rd_data;
  logic [5:0] wr_addr;
  rap_spi_state_type spi_state;
  logic stamp_active;
  logic ind_mode;
  logic ind_locked;
  logic timestamp_pin_enable;
  logic buffer_empty_ind_enable;
  logic retry_tx_stamp_enable;
  logic antenna_switch_drive_enable;
  logic [1:0] antenna_static_select;
  logic stamp_set;
  logic next_switch_pos;
  logic next_switch_neg;

  localparam int IND_VALID_LIMIT = IND_VALID_CYCLES;

  function automatic logic [7:0] reg_value(input logic [5:0] addr, input logic [7:0] ctrl,
                                           input logic [7:0] ext, input logic [7:0] ant);
    logic [7:0] value;
    value = 8'h00;
    if (addr == TRX_CTRL_ONE_ADDR)
    begin
      value = ctrl;
    end
    else if (addr == EXT_MODE_CTRL_ONE_ADDR)
    begin
      value = ext & EXT_MODE_CTRL_ONE_MASK;
    end
    else if (addr == ANT_DIV_CTRL_ADDR)
    begin
      value = ant & ANT_DIV_CTRL_MASK;
    end
    return value;
  endfunction

  rap_pin_sync #(
    .WIDTH(3),
    .RESET_VAL(PIN_SYNC_RESET)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({spi_sel_n, spi_mosi, spi_sclk}),
    .pin_out({sel_n_s, mosi_s, sclk_s})
  );

  rap_spi_shift u_shift (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sclk(sclk_s),
    .mosi(mosi_s),
    .sel_n(sel_n_s),
    .tx_byte(rd_data),
    .byte_done(byte_done),
    .rx_byte(rx_byte),
    .miso(miso_raw)
  );

  assign timestamp_pin_enable = transceiver_control_one[TS_PIN_EN_BIT];
  assign buffer_empty_ind_enable = transceiver_control_one[BUF_IND_EN_BIT];
  assign retry_tx_stamp_enable = extended_mode_control_one[RETRY_STAMP_EN_BIT];
  assign antenna_switch_drive_enable = antenna_diversity_control[SW_DRIVE_EN_BIT];
  assign antenna_static_select = antenna_diversity_control[ANT_SEL_LSB +: 2];

  // Command decoding; the first byte of every select frame picks the access kind.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      spi_state <= SPI_IDLE;
      wr_addr <= 6'h00;
      rd_data <= 8'h00;
    end
    else if (sel_n_s)
    begin
      spi_state <= SPI_IDLE;
    end
    else if (byte_done && spi_state == SPI_IDLE)
    begin
      wr_addr <= rx_byte[5:0];
      if (rx_byte[7:6] == CMD_REG_WRITE)
      begin
        spi_state <= SPI_REG_WRITE;
      end
      else if (rx_byte[7:6] == CMD_REG_READ)
      begin
        spi_state <= SPI_REG_READ;
        rd_data <= reg_value(rx_byte[5:0], transceiver_control_one,
                             extended_mode_control_one, antenna_diversity_control);
      end
      else if (rx_byte[7:5] == CMD_FRAME_READ)
      begin
        spi_state <= SPI_FRAME_READ;
      end
      else
      begin
        spi_state <= SPI_OTHER;
      end
    end
    else if (byte_done && spi_state == SPI_REG_WRITE)
    begin
      spi_state <= SPI_OTHER;
    end
    else if (byte_done && spi_state == SPI_REG_READ)
    begin
      spi_state <= SPI_OTHER;
      rd_data <= 8'h00;
    end
  end

  // Register writes; the stamp pin enable is never set on the host's behalf.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      transceiver_control_one <= TRX_CTRL_ONE_RESET;
      extended_mode_control_one <= EXT_MODE_CTRL_ONE_RESET;
      antenna_diversity_control <= ANT_DIV_CTRL_RESET;
    end
    else if (byte_done && spi_state == SPI_REG_WRITE && !sel_n_s)
    begin
      if (wr_addr == TRX_CTRL_ONE_ADDR)
      begin
        transceiver_control_one <= rx_byte;
      end
      else if (wr_addr == EXT_MODE_CTRL_ONE_ADDR)
      begin
        extended_mode_control_one <= rx_byte & EXT_MODE_CTRL_ONE_MASK;
      end
      else if (wr_addr == ANT_DIV_CTRL_ADDR)
      begin
        antenna_diversity_control <= rx_byte & ANT_DIV_CTRL_MASK;
      end
    end
  end

  // Receive stamps in any receive mode, transmit stamps only in auto-retry mode.
  // No interrupt mask takes part here, so a masked receive-start still stamps.
  assign stamp_set = timestamp_pin_enable &
                     (core_evt.rx_phr_valid |
                      (core_evt.tx_frame_start & auto_retry_tx_mode &
                       retry_tx_stamp_enable));

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stamp_active <= 1'b0;
    end
    else if (stamp_set)
    begin
      stamp_active <= 1'b1;
    end
    else if (core_evt.frame_end || !timestamp_pin_enable)
    begin
      stamp_active <= 1'b0;
    end
  end

  // Indicator mode spans the frame read after its command byte until select returns high.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ind_mode <= 1'b0;
      ind_locked <= 1'b0;
    end
    else if (sel_n_s)
    begin
      ind_mode <= 1'b0;
      ind_locked <= 1'b0;
    end
    else
    begin
      if (byte_done && spi_state == SPI_IDLE && rx_byte[7:5] == CMD_FRAME_READ &&
          buffer_empty_ind_enable)
      begin
        ind_mode <= 1'b1;
      end
      if (ind_mode && core_evt.rx_error)
      begin
        ind_locked <= 1'b1;
      end
    end
  end

  always_comb
  begin
    next_switch_pos = 1'b0;
    next_switch_neg = 1'b0;
    if (antenna_switch_drive_enable)
    begin
      if (antenna_static_select == ANT_SEL_ZERO)
      begin
        next_switch_neg = 1'b1;
      end
      else if (antenna_static_select == ANT_SEL_ONE)
      begin
        next_switch_pos = 1'b1;
      end
    end
    if (timestamp_pin_enable)
    begin
      next_switch_neg = stamp_active;
    end
  end

  // The indicator has a fixed high-means-empty sense; irq_pending already carries polarity.
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pins <= '{switch_pos: 1'b0, switch_neg: 1'b0, irq_pin: 1'b0,
                miso: 1'b0, miso_oe_n: 1'b1};
    end
    else
    begin
      pins.switch_pos <= next_switch_pos;
      pins.switch_neg <= next_switch_neg;
      pins.irq_pin <= ind_mode ? (ind_locked | ~buffer_data_ready) : irq_pending;
      pins.miso <= miso_raw;
      pins.miso_oe_n <= sel_n_s;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ant_zero_sel_a: assert property (antenna_switch_drive_enable && antenna_static_select == 2'h1
    && !timestamp_pin_enable |=> !pins.switch_pos && pins.switch_neg)
    else $error("antenna 0 select not driven");
  ant_one_sel_a: assert property (antenna_switch_drive_enable && antenna_static_select == 2'h2
    |=> pins.switch_pos && (timestamp_pin_enable || !pins.switch_neg))
    else $error("antenna 1 select not driven");
  ant_none_sel_a: assert property ((antenna_static_select == 2'h0 || antenna_static_select == 2'h3)
    && !timestamp_pin_enable |=> !pins.switch_pos && !pins.switch_neg)
    else $error("select 0 or 3 drove a switch output");
  stamp_rise_a: assert property (stamp_set |=> stamp_active ##1 pins.switch_neg)
    else $error("stamp output did not rise");
  stamp_hold_a: assert property (stamp_active && !core_evt.frame_end && timestamp_pin_enable
    |=> stamp_active [*1] ##0 pins.switch_neg)
    else $error("stamp output dropped before frame end");
  tx_retry_only_a: assert property (!stamp_active && !core_evt.rx_phr_valid
    && core_evt.tx_frame_start && !auto_retry_tx_mode |=> !stamp_active)
    else $error("transmit stamp outside auto-retry mode");
  pin_ground_a: assert property (!timestamp_pin_enable && !antenna_switch_drive_enable
    |=> !pins.switch_neg && !pins.switch_pos)
    else $error("unused switch pins not grounded");
  ind_enter_a: assert property (byte_done && spi_state == SPI_IDLE && !sel_n_s
    && rx_byte[7:5] == CMD_FRAME_READ && buffer_empty_ind_enable |=> ind_mode)
    else $error("indicator mode not entered");
  ind_sense_a: assert property (ind_mode && !ind_locked
    |=> pins.irq_pin == !$past(buffer_data_ready))
    else $error("indicator level wrong");
  ind_valid_a: assert property (byte_done && spi_state == SPI_IDLE && !sel_n_s
    && rx_byte[7:5] == CMD_FRAME_READ && buffer_empty_ind_enable
    |-> ##[1:IND_VALID_LIMIT] (ind_mode && pins.irq_pin == (ind_locked | !buffer_data_ready)))
    else $error("indicator not valid in time");
  irq_only_a: assert property (!ind_mode |=> pins.irq_pin == $past(irq_pending))
    else $error("interrupt not shown outside indicator mode");
  ind_lock_a: assert property (ind_mode && core_evt.rx_error && !sel_n_s
    |=> ind_locked ##1 (pins.irq_pin || !ind_mode))
    else $error("receive error did not lock indicator");

  frame_read_c: cover property (ind_mode ##1 !buffer_data_ready ##1 buffer_data_ready);
  rx_stamp_c: cover property (core_evt.rx_phr_valid && timestamp_pin_enable ##[1:50] core_evt.frame_end);
  reg_write_c: cover property (byte_done && spi_state == SPI_REG_WRITE);
  ant_switch_c: cover property (pins.switch_pos ##[1:100] pins.switch_neg);

endmodule

// ===== sim/rap_host_model.sv
// Host microcontroller model that drives the serial port and watches the indicator pin.
`timescale 1ns/1ps
module rap_host_model
  import rap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic miso,
  input wire logic irq_pin,
  output logic sclk,
  output logic mosi,
  output logic sel_n
);
  // Half of the 160 ns serial clock in reference cycles.
  localparam int HALF = 8;
  // Two byte times at 250 kb/s in reference cycles.
  localparam int IND_TIMEOUT = 6400;

  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
  end

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge ref_clk);
      mosi = tx[i];
      repeat (HALF) @(negedge ref_clk);
      rx[i] = miso;
      sclk = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      sclk = 1'b0;
    end
    // The data line shows a changed level once no bit is being sent.
    mosi = ~tx[0];
  endtask

  task automatic frame_begin();
    @(negedge ref_clk);
    sel_n = 1'b0;
    repeat (HALF) @(negedge ref_clk);
  endtask

  task automatic frame_end();
    repeat (HALF) @(negedge ref_clk);
    sel_n = 1'b1;
    repeat (2 * HALF) @(negedge ref_clk);
  endtask

  task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
    logic [7:0] rx;
    frame_begin();
    xfer({CMD_REG_WRITE, addr}, rx);
    xfer(data, rx);
    frame_end();
  endtask

  task automatic reg_read(input logic [5:0] addr, output logic [7:0] data);
    logic [7:0] rx;
    frame_begin();
    xfer({CMD_REG_READ, addr}, rx);
    xfer(8'h00, data);
    frame_end();
  endtask

  // The indicator is not trusted before its settling time has passed.
  task automatic frame_cmd();
    logic [7:0] rx;
    frame_begin();
    xfer({CMD_FRAME_READ, 5'h00}, rx);
    repeat (IND_VALID_CYCLES) @(negedge ref_clk);
  endtask

  // Waits for the indicator to go low and gives up after two byte times.
  task automatic wait_ind(output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (n < IND_TIMEOUT && ok !== 1'b1)
    begin
      @(negedge ref_clk);
      ok = (irq_pin === 1'b0);
      n++;
    end
  endtask
endmodule

// ===== sim/testbench.sv
// Testbench for the auxiliary pin block: registers, antenna outputs, stamping, indicator.
`timescale 1ns/1ps
module testbench
  import rap_pkg::*;
;
  logic ref_clk;
  logic sys_rst;
  logic sclk;
  logic mosi;
  logic sel_n;
  rap_core_evt_type core_evt;
  logic auto_retry;
  logic ready;
  logic irq_pending;
  rap_pins_type pins;
  int fails;
  int n_tests;
  logic [7:0] rd;
  logic ok;
  logic [5:0] t_addr [4] = '{6'h04, 6'h17, 6'h0D, 6'h3F};
  logic [7:0] t_exp [4] = '{8'hA5, 8'hF7, 8'h07, 8'h00};

  rap_aux_pins i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_sel_n(sel_n), .core_evt(core_evt), .auto_retry_tx_mode(auto_retry),
    .buffer_data_ready(ready), .irq_pending(irq_pending), .pins(pins));

  rap_host_model i_host (.ref_clk(ref_clk), .miso(pins.miso), .irq_pin(pins.irq_pin),
    .sclk(sclk), .mosi(mosi), .sel_n(sel_n));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_sw(input logic p, input logic n);
    chk("switch", {6'h00, pins.switch_pos, pins.switch_neg}, {6'h00, p, n});
  endtask

  task automatic chk_irq(input logic e);
    chk("irq_pin", {7'h00, pins.irq_pin}, {7'h00, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic pulse(input logic [3:0] e);
    @(negedge ref_clk);
    core_evt = e;
    @(negedge ref_clk);
    core_evt = 4'h0;
    cyc(3);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #500000;
    fails++;
    end_sim();
  end

  initial
  begin
    fails = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    core_evt = 4'h0;
    auto_retry = 1'b0;
    ready = 1'b0;
    irq_pending = 1'b0;
    cyc(16);
    sys_rst = 1'b0;
    cyc(8);
    chk_sw(1'b0, 1'b0);
    chk("miso_oe_n", {7'h00, pins.miso_oe_n}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      i_host.reg_read(t_addr[i], rd);
      chk("reset value", rd, 8'h00);
      i_host.reg_write(t_addr[i], 8'hFF & (i == 0 ? 8'hA5 : 8'hFF));
      i_host.reg_read(t_addr[i], rd);
      chk("readback", rd, t_exp[i]);
      i_host.reg_write(t_addr[i], 8'h00);
    end
    for (int s = 0; s < 4; s++)
    begin
      i_host.reg_write(ANT_DIV_CTRL_ADDR, {5'h00, 1'b1, 2'(s)});
      chk_sw(s == 2, s == 1);
    end
    i_host.reg_write(ANT_DIV_CTRL_ADDR, 8'h02);
    chk_sw(1'b0, 1'b0);
    i_host.reg_write(ANT_DIV_CTRL_ADDR, 8'h06);
    i_host.reg_write(TRX_CTRL_ONE_ADDR, 8'h40);
    chk_sw(1'b1, 1'b0);
    pulse(4'h8);
    chk_sw(1'b1, 1'b1);
    cyc(40);
    chk_sw(1'b1, 1'b1);
    pulse(4'h2);
    chk_sw(1'b1, 1'b0);
    i_host.reg_write(EXT_MODE_CTRL_ONE_ADDR, 8'h80);
    pulse(4'h4);
    chk_sw(1'b1, 1'b0);
    auto_retry = 1'b1;
    pulse(4'h4);
    chk_sw(1'b1, 1'b1);
    pulse(4'h2);
    i_host.reg_write(TRX_CTRL_ONE_ADDR, 8'h00);
    pulse(4'h4);
    chk_sw(1'b1, 1'b0);
    i_host.reg_write(ANT_DIV_CTRL_ADDR, 8'h00);
    i_host.reg_write(TRX_CTRL_ONE_ADDR, 8'h10);
    irq_pending = 1'b1;
    cyc(3);
    chk_irq(1'b1);
    irq_pending = 1'b0;
    i_host.frame_begin();
    i_host.xfer(8'h40, rd);
    cyc(IND_VALID_CYCLES);
    chk_irq(1'b0);
    chk("miso_oe_n", {7'h00, pins.miso_oe_n}, 8'h00);
    i_host.frame_end();
    i_host.frame_cmd();
    chk_irq(1'b1);
    irq_pending = 1'b1;
    ready = 1'b1;
    cyc(3);
    chk_irq(1'b0);
    i_host.wait_ind(ok);
    chk("ready", {7'h00, ok}, 8'h01);
    i_host.xfer(8'h00, rd);
    pulse(4'h1);
    chk_irq(1'b1);
    i_host.wait_ind(ok);
    chk("locked", {7'h00, ok}, 8'h00);
    irq_pending = 1'b0;
    i_host.frame_end();
    chk_irq(1'b0);
    i_host.reg_write(TRX_CTRL_ONE_ADDR, 8'h00);
    ready = 1'b0;
    i_host.frame_cmd();
    chk_irq(1'b0);
    irq_pending = 1'b1;
    cyc(3);
    chk_irq(1'b1);
    i_host.frame_end();
    end_sim();
  end
endmodule
